// File: clock_mode_defs.svh
/*
  Constants of the clock mode select and divider block: mode codes,
  decode bases, prescale values and the mode settle count.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CLOCK_MODE_DEFS_SVH
`define CLOCK_MODE_DEFS_SVH

// Mode codes shared by the request and the status fields
`define CMS_MODE_SELF      2'h0
`define CMS_MODE_FLL_INT   2'h1
`define CMS_MODE_BYPASS    2'h2
`define CMS_MODE_FLL_EXT   2'h3

// Cycles between a mode request and its first evaluation
`define CMS_SETTLE_CYCLES  3'h4

// Multiplier decode: base plus step per code
`define CMS_MULT_BASE      5'h04
`define CMS_MULT_STEP      5'h02

// Prescale factor per range setting
`define CMS_PRESCALE_LOW   7'h40
`define CMS_PRESCALE_HIGH  7'h01

// Least product ratio for the reference-derived fixed clock
`define CMS_RATIO_MIN      12'h004

// Fixed dividers
`define CMS_IRC_DIVISOR    9'h007
`define CMS_BUS_DIVISOR    9'h002
`define CMS_FIXED_DIVISOR  9'h002

`endif

// File: clock_mode_pkg.sv
/*
  Types of the clock mode select and divider block.
  Assumes clock_mode_defs.svh is compiled alongside.
*/
package clock_mode_pkg;

  typedef enum logic {SW_STEADY, SW_WAIT} switch_phase_t;

  // First control register fields
  typedef struct packed {
    logic       highGain;
    logic       rangeSel;
    logic       refSel;
    logic [1:0] mode;
  } ctrl_one_t;

  // Second control register fields
  typedef struct packed {
    logic [2:0] multCode;
    logic [2:0] divCode;
  } ctrl_two_t;

  // Status levels from the loop and the clock monitors
  typedef struct packed {
    logic dcoStable;
    logic extRefStable;
    logic lossOfClock;
    logic fllLocked;
    logic lossOfRef;
    logic lossOfDco;
  } flags_t;

  typedef struct packed {
    logic meta;
    logic stable;
    logic prev;
    logic rise;
  } sync_state_t;

  typedef struct packed {
    logic [8:0] cnt;
    logic       tick;
  } div_state_t;

  typedef struct packed {
    switch_phase_t phase;
    logic [2:0]    settleCnt;
    logic [1:0]    reqMode;
    logic [1:0]    actMode;
    logic          refSel;
    logic          refSelLocked;
    logic          firstWriteDone;
    logic          highGain;
    logic          gainWritten;
    logic          rangeSel;
    logic [2:0]    multCode;
    logic [2:0]    divCode;
    logic          halfRate;
    logic [8:0]    outDivisor;
    logic          fixedOut;
  } state_t;

endpackage : clock_mode_pkg

// File: sync_edge.sv
/*
  Two-flop synchroniser with rising-edge pulse for a pin clock.
  Assumes pinIn is asynchronous to sys_clk and much slower than it.
*/
module sync_edge (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic pinIn,
  output logic      riseTick
);

  clock_mode_pkg::sync_state_t s_reg;
  clock_mode_pkg::sync_state_t s_next;

  // Edge is taken only from the second flop onward
  always_comb begin
    s_next        = s_reg;
    s_next.meta   = pinIn;
    s_next.stable = s_reg.meta;
    s_next.prev   = s_reg.stable;
    s_next.rise   = s_reg.stable & ~s_reg.prev;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign riseTick = s_reg.rise;

endmodule : sync_edge

// File: div_counter.sv
/*
  Event divider: one tick for every divisor input events.
  Assumes divisor is at least one; a shrinking divisor wraps safely.
*/
module div_counter (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       eventIn,
  input  wire logic [8:0] divisor,
  output logic            tick
);

  clock_mode_pkg::div_state_t s_reg;
  clock_mode_pkg::div_state_t s_next;

  // Count events, tick and restart at the last one
  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (eventIn) begin
      if (s_reg.cnt + 9'h001 >= divisor) begin
        s_next.cnt  = 9'h000;
        s_next.tick = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 9'h001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;

endmodule : div_counter

// File: clock_mode_select.sv
/*
  Clock mode selection and output derivation of the clock generator:
  mode request and status, entry gating, fallback on clock loss,
  output and fixed-frequency clock ticks, write-once oscillator gain.
  Assumes the loop, lock and loss detectors sit outside on sys_clk and
  the raw DCO, external and internal reference clocks arrive as pins.
  Each derived clock is a one-cycle tick per period of that clock.
*/
`include "clock_mode_defs.svh"

// Overview of operation
// R1: Accept requested mode, report actual mode
// R2: Status follows request only after settle delay
// R3: First write without crystal locks reference off
// R4: Enter modes only when stability flags allow
// R5: Self-clocked granted unless leaving bypass mode
// R6: Internal reference over seven clocks comparisons only
// R7: External loop outputs half rate until locked
// R8: Fixed clock equals bus clock otherwise
// R9: Fixed clock from reference when ratio, lock
// R10: Fixed clock stopped in internal loop, self-clocked
// R11: Peripherals avoid fixed clock in those modes
// R12: High-gain bit selects oscillator gain
// R13: High gain acts only with reference selected
// R14: High-gain bit written once per reset
// R15: Output frequency per mode from source, P, N, R
// R16: Prescale 64 for low range, 1 high
// R17: Multiplier decodes four plus two per code
// R18: Divider decodes as power of two
// R19: Clock loss fallback updates request and status
module clock_mode_select (
  input  wire logic                      sys_clk,
  input  wire logic                      arst_n,
  input  wire logic                      ctrlOneWrite,
  input  wire clock_mode_pkg::ctrl_one_t ctrlOneData,
  input  wire logic                      ctrlTwoWrite,
  input  wire clock_mode_pkg::ctrl_two_t ctrlTwoData,
  input  wire clock_mode_pkg::flags_t    flags,
  input  wire logic                      dcoClockPin,
  input  wire logic                      extRefClockPin,
  input  wire logic                      intRefClockPin,
  output logic [1:0]                     requestedModeSel,
  output logic [1:0]                     actualModeStat,
  output logic                           referenceSelect,
  output logic                           oscAmpEnable,
  output logic                           highGainSel,
  output logic                           highGainActive,
  output logic                           halfRateActive,
  output logic [4:0]                     multiplierN,
  output logic [7:0]                     dividerR,
  output logic [6:0]                     prescaleP,
  output logic                           generatorOutputTick,
  output logic                           internalBusTick,
  output logic                           fixedFreqTick,
  output logic                           compareRefTick
);

  clock_mode_pkg::state_t s_reg;
  clock_mode_pkg::state_t s_next;

  logic        dcoRise;
  logic        extRefRise;
  logic        intRefRise;
  logic        outSrcEvent;
  logic        busTick;
  logic        fixedRefTick;
  logic [10:0] productPN;
  logic [11:0] ratioBound;
  logic        ratioOk;
  logic        fallbackNow;

  // Multiplier from the three-bit code
  function automatic logic [4:0] decode_mult(input logic [2:0] code);
    decode_mult = `CMS_MULT_BASE + `CMS_MULT_STEP * {2'h0, code}; // R17
  endfunction : decode_mult

  // Divider from the three-bit code
  function automatic logic [7:0] decode_div(input logic [2:0] code);
    decode_div = 8'h01 << code; // R18
  endfunction : decode_div

  // Prescale from the range setting
  function automatic logic [6:0] decode_pre(input logic rangeSel);
    decode_pre = rangeSel ? `CMS_PRESCALE_HIGH : `CMS_PRESCALE_LOW; // R16
  endfunction : decode_pre

  // Entry conditions of a requested mode
  function automatic logic mode_allowed(
    input logic [1:0]             req,
    input logic [1:0]             act,
    input clock_mode_pkg::flags_t f
  );
    case (req)
      `CMS_MODE_SELF:    mode_allowed = (act != `CMS_MODE_BYPASS); // R5
      `CMS_MODE_FLL_INT: mode_allowed = f.dcoStable; // R4
      `CMS_MODE_BYPASS:  mode_allowed = f.extRefStable; // R4
      `CMS_MODE_FLL_EXT: mode_allowed = f.dcoStable & f.extRefStable &
        ~((act == `CMS_MODE_BYPASS) & f.lossOfClock); // R4
      default:           mode_allowed = 1'b0;
    endcase
  endfunction : mode_allowed

  // Pin clocks into the system domain
  sync_edge dcoSync (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .pinIn    (dcoClockPin),
    .riseTick (dcoRise)
  );

  sync_edge extRefSync (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .pinIn    (extRefClockPin),
    .riseTick (extRefRise)
  );

  sync_edge intRefSync (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .pinIn    (intRefClockPin),
    .riseTick (intRefRise)
  );

  // Output clock source: reference in bypass, DCO otherwise
  assign outSrcEvent = (s_reg.actMode == `CMS_MODE_BYPASS) ?
                       extRefRise : dcoRise; // R15

  // Output clock divided by R or 2R
  div_counter outDiv (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .eventIn (outSrcEvent),
    .divisor (s_reg.outDivisor),
    .tick    (generatorOutputTick)
  );

  // Bus clock is half the output clock
  div_counter busDiv (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .eventIn (generatorOutputTick),
    .divisor (`CMS_BUS_DIVISOR),
    .tick    (busTick)
  );

  // External reference over two for the fixed clock
  div_counter fixedDiv (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .eventIn (extRefRise),
    .divisor (`CMS_FIXED_DIVISOR),
    .tick    (fixedRefTick)
  );

  // Internal reference over seven, comparison clock only
  div_counter ircDiv (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .eventIn (intRefRise),
    .divisor (`CMS_IRC_DIVISOR),
    .tick    (compareRefTick) // R6
  );

  // Ratio test P*N/R >= 4 done as P*N >= 4*R
  assign productPN  = {4'h0, prescaleP} * {6'h00, multiplierN};
  assign ratioBound = `CMS_RATIO_MIN * {4'h0, dividerR};
  assign ratioOk    = ({1'b0, productPN} >= ratioBound); // R9

  // Monitor-forced fallback out of the external modes
  assign fallbackNow = (flags.lossOfRef &&
                        (s_reg.actMode == `CMS_MODE_FLL_EXT ||
                         s_reg.actMode == `CMS_MODE_BYPASS)) ||
                       (flags.lossOfDco &&
                        s_reg.actMode == `CMS_MODE_FLL_EXT);

  // Next state of the whole block
  always_comb begin
    s_next = s_reg;
    // Software write of the first control register
    if (ctrlOneWrite) begin
      s_next.reqMode   = ctrlOneData.mode; // R1
      s_next.phase     = clock_mode_pkg::SW_WAIT; // R2
      s_next.settleCnt = `CMS_SETTLE_CYCLES;
      s_next.rangeSel  = ctrlOneData.rangeSel;
      if (!s_reg.firstWriteDone) begin
        s_next.firstWriteDone = 1'b1;
        if (ctrlOneData.refSel && ctrlOneData.mode[1]) begin
          s_next.refSel = 1'b1;
        end else begin
          s_next.refSel     = 1'b0; // R3
          s_next.refSelLocked = 1'b1;
        end
      end else if (!s_reg.refSelLocked) begin
        s_next.refSel = ctrlOneData.refSel;
      end
      if (!s_reg.gainWritten) begin
        s_next.highGain    = ctrlOneData.highGain; // R12
        s_next.gainWritten = 1'b1; // R14
      end
    end
    // Lock ends the half-rate phase; later sets win
    if (flags.fllLocked) begin
      s_next.halfRate = 1'b0;
    end
    // Software write of multiplier and divider
    if (ctrlTwoWrite) begin
      s_next.multCode = ctrlTwoData.multCode;
      s_next.divCode  = ctrlTwoData.divCode;
      if (s_reg.actMode == `CMS_MODE_FLL_EXT &&
          ctrlTwoData.multCode != s_reg.multCode) begin
        s_next.halfRate = 1'b1; // R7
      end
    end
    // Settle delay, then track the request while allowed
    case (s_reg.phase)
      clock_mode_pkg::SW_WAIT: begin
        if (!ctrlOneWrite) begin
          if (s_reg.settleCnt <= 3'h1) begin
            s_next.phase = clock_mode_pkg::SW_STEADY;
          end else begin
            s_next.settleCnt = s_reg.settleCnt - 3'h1; // R2
          end
        end
      end
      clock_mode_pkg::SW_STEADY: begin
        if (!ctrlOneWrite && s_reg.reqMode != s_reg.actMode &&
            mode_allowed(s_reg.reqMode, s_reg.actMode, flags)) begin
          s_next.actMode = s_reg.reqMode; // R4
          if (s_reg.reqMode == `CMS_MODE_FLL_EXT) begin
            s_next.halfRate = 1'b1; // R7
          end
        end
      end
      default: begin
        s_next.phase = clock_mode_pkg::SW_STEADY;
      end
    endcase
    // Fallback has priority over any request
    if (fallbackNow) begin
      s_next.phase = clock_mode_pkg::SW_STEADY;
      if (flags.lossOfRef) begin
        s_next.actMode = `CMS_MODE_SELF; // R19
        s_next.reqMode = `CMS_MODE_SELF;
      end else begin
        s_next.actMode = `CMS_MODE_BYPASS; // R19
        s_next.reqMode = `CMS_MODE_BYPASS;
      end
      s_next.halfRate = 1'b0;
    end
    // Output divisor, doubled while the loop locks or relocks after a multiplier change
    s_next.outDivisor = s_reg.halfRate ?
                        {decode_div(s_reg.divCode), 1'b0} :
                        {1'b0, decode_div(s_reg.divCode)}; // R7
    // Fixed clock source per mode
    case (s_reg.actMode)
      `CMS_MODE_FLL_EXT: begin
        s_next.fixedOut = (ratioOk && flags.fllLocked) ?
                          fixedRefTick : busTick; // R9
      end
      `CMS_MODE_BYPASS: begin
        s_next.fixedOut = busTick; // R8
      end
      default: begin
        s_next.fixedOut = 1'b0; // R10
      end
    endcase
  end

  // State register; reset lands in self-clocked mode
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg            <= '0;
      s_reg.phase      <= clock_mode_pkg::SW_STEADY;
      s_reg.outDivisor <= 9'h001;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign requestedModeSel = s_reg.reqMode; // R1
  assign actualModeStat   = s_reg.actMode; // R1
  assign referenceSelect  = s_reg.refSel;
  assign oscAmpEnable     = s_reg.refSel; // R3
  assign highGainSel      = s_reg.highGain;
  assign highGainActive   = s_reg.highGain & s_reg.refSel; // R13
  assign halfRateActive   = s_reg.halfRate;
  assign multiplierN      = decode_mult(s_reg.multCode);
  assign dividerR         = decode_div(s_reg.divCode);
  assign prescaleP        = decode_pre(s_reg.rangeSel);
  assign internalBusTick  = busTick;
  assign fixedFreqTick    = s_reg.fixedOut;

  // Checks on the mode logic
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  mode_write_delay_a: assert property ( // R2
    ctrlOneWrite && !fallbackNow |=> $stable(actualModeStat)
  ) else $error("mode status moved right after a request");

  ext_loop_entry_a: assert property ( // R4
    actualModeStat == `CMS_MODE_FLL_EXT &&
    $past(actualModeStat) != `CMS_MODE_FLL_EXT |->
    $past(flags.dcoStable) && $past(flags.extRefStable)
  ) else $error("external loop mode entered without stable clocks");

  int_loop_entry_a: assert property ( // R4
    actualModeStat == `CMS_MODE_FLL_INT &&
    $past(actualModeStat) != `CMS_MODE_FLL_INT |->
    $past(flags.dcoStable)
  ) else $error("internal loop mode entered without stable DCO");

  bypass_fee_block_a: assert property ( // R4
    actualModeStat == `CMS_MODE_BYPASS && flags.lossOfClock &&
    !fallbackNow |=> actualModeStat != `CMS_MODE_FLL_EXT
  ) else $error("bypass to external loop while clock lost");

  self_from_bypass_a: assert property ( // R5
    actualModeStat == `CMS_MODE_SELF &&
    $past(actualModeStat) == `CMS_MODE_BYPASS |-> $past(fallbackNow)
  ) else $error("self-clocked entered from bypass on request");

  fixed_stopped_a: assert property ( // R10
    actualModeStat == `CMS_MODE_SELF ||
    actualModeStat == `CMS_MODE_FLL_INT |=> !fixedFreqTick
  ) else $error("fixed clock ran in an internal mode");

  ref_lock_a: assert property ( // R3
    s_reg.refSelLocked |-> !referenceSelect ##1 !referenceSelect
  ) else $error("locked reference select came up");

  gain_once_a: assert property ( // R14
    s_reg.gainWritten && ctrlOneWrite |=> $stable(highGainSel)
  ) else $error("high-gain bit changed on a later write");

  relock_half_a: assert property ( // R7
    ctrlTwoWrite && actualModeStat == `CMS_MODE_FLL_EXT &&
    ctrlTwoData.multCode != s_reg.multCode && !fallbackNow |=>
    halfRateActive ##1 dividerR == 8'(s_reg.outDivisor >> 1)
  ) else $error("no half rate after multiplier change");

  fallback_sync_a: assert property ( // R19
    fallbackNow |=> requestedModeSel == actualModeStat
  ) else $error("fallback left request and status apart");

endmodule : clock_mode_select

// File: ext_clock_source.sv
/*
  Behavioural far-side clock source: crystal, resonator or oscillator.
  Assumes the half period is well above two sys_clk periods.
*/
module ext_clock_source #(
  parameter int HALF_NS = 100
) (
  input  wire logic run,
  output logic      clkOut
);
  timeunit 1ns;
  timeprecision 100ps;

  // Toggles while running, rests low when stopped
  initial begin
    clkOut = 1'b0;
    forever begin
      #(HALF_NS);
      clkOut = run ? ~clkOut : 1'b0;
    end
  end
endmodule : ext_clock_source

// File: clock_mode_select_tb.sv
/*
  Self-checking bench of clock_mode_select: requests, entry gating,
  fallback, decode, derived clock rates and write-once gain.
  Assumes clock_mode_pkg and ext_clock_source are compiled first.
*/
module clock_mode_select_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic                      sysClk;
  logic                      arstN;
  logic                      wr1;
  clock_mode_pkg::ctrl_one_t d1;
  logic                      wr2;
  clock_mode_pkg::ctrl_two_t d2;
  clock_mode_pkg::flags_t    flags;
  logic                      extRun;
  logic                      dcoPin;
  logic                      extPin;
  logic                      intPin;
  logic [1:0]                reqMode;
  logic [1:0]                actMode;
  logic                      refSel;
  logic                      ampEn;
  logic                      hgSel;
  logic                      hgAct;
  logic                      halfRate;
  logic [4:0]                nVal;
  logic [7:0]                rVal;
  logic [6:0]                pVal;
  logic                      outTick;
  logic                      busTick;
  logic                      fixTick;
  logic                      cmpTick;
  int                        cOut;
  int                        cBus;
  int                        cFix;
  int                        cCmp;
  int                        error_cnt;
  int                        total_checks;

  ext_clock_source #(.HALF_NS(75)) dcoSrc (.run(1'b1), .clkOut(dcoPin));
  ext_clock_source #(.HALF_NS(100)) extSrc (.run(extRun), .clkOut(extPin));
  ext_clock_source #(.HALF_NS(125)) intSrc (.run(1'b1), .clkOut(intPin));

  clock_mode_select uut (
    .sys_clk(sysClk), .arst_n(arstN),
    .ctrlOneWrite(wr1), .ctrlOneData(d1),
    .ctrlTwoWrite(wr2), .ctrlTwoData(d2), .flags(flags),
    .dcoClockPin(dcoPin), .extRefClockPin(extPin),
    .intRefClockPin(intPin),
    .requestedModeSel(reqMode), .actualModeStat(actMode),
    .referenceSelect(refSel), .oscAmpEnable(ampEn),
    .highGainSel(hgSel), .highGainActive(hgAct),
    .halfRateActive(halfRate), .multiplierN(nVal), .dividerR(rVal),
    .prescaleP(pVal), .generatorOutputTick(outTick),
    .internalBusTick(busTick), .fixedFreqTick(fixTick),
    .compareRefTick(cmpTick)
  );

  // Clock at 40 MHz
  initial begin
    sysClk = 1'b0;
    forever #12.5 sysClk = ~sysClk;
  end

  // Running tick counters
  always @(posedge sysClk) begin
    cOut <= cOut + int'(outTick === 1'b1);
    cBus <= cBus + int'(busTick === 1'b1);
    cFix <= cFix + int'(fixTick === 1'b1);
    cCmp <= cCmp + int'(cmpTick === 1'b1);
  end

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic tick(input int n);
    repeat (n) @(posedge sysClk);
    #2;
  endtask : tick

  task automatic doReset;
    arstN = 1'b0;
    flags = '0;
    tick(8);
    arstN = 1'b1;
  endtask : doReset

  task automatic wrOne(input logic hg, rng, rs, input logic [1:0] m);
    wr1 = 1'b1;
    d1  = '{highGain: hg, rangeSel: rng, refSel: rs, mode: m};
    tick(1);
    wr1 = 1'b0;
    tick(1);
  endtask : wrOne

  task automatic wrTwo(input logic [2:0] mc, dc);
    wr2 = 1'b1;
    d2  = '{multCode: mc, divCode: dc};
    tick(1);
    wr2 = 1'b0;
    tick(1);
  endtask : wrTwo

  task automatic waitMode(input logic [1:0] m);
    int i;
    i = 0;
    while (actMode !== m && i < 20) begin
      tick(1);
      i++;
    end
    check("actualModeStat", 16'(actMode), 16'(m));
    if (actMode !== m) report_and_stop();
  endtask : waitMode

  // Count within tolerance, exact when zero is expected
  task automatic near(input string name, input int seen, exp, tol);
    int t;
    t = (exp == 0) ? 0 : tol;
    check(name, 16'((seen >= exp - t && seen <= exp + t) ? exp : seen),
          16'(exp));
  endtask : near

  // Ticks over 1200 cycles against expected counts
  task automatic measure(input int eo, eb, ef, ec);
    int o, b, f, c;
    o = cOut;
    b = cBus;
    f = cFix;
    c = cCmp;
    tick(1200);
    near("generatorOutputTick", cOut - o, eo, 2);
    near("internalBusTick", cBus - b, eb, 2);
    near("fixedFreqTick", cFix - f, ef, 2);
    if (ec >= 0) near("compareRefTick", cCmp - c, ec, 2);
  endtask : measure

  // Hang guard
  initial begin
    #2500000;
    error_cnt++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    int f;
    {arstN, wr1, wr2, cOut, cBus, cFix, cCmp} = '0;
    {d1, d2, flags, error_cnt, total_checks} = '0;
    extRun = 1'b1;
    doReset();
    check("requestedModeSel", 16'(reqMode), 16'h0000);
    check("actualModeStat", 16'(actMode), 16'h0000);
    check("prescaleP", 16'(pVal), 16'h0040);
    for (int k = 0; k < 8; k++) begin
      wrTwo(3'(k), 3'(k));
      check("multiplierN", 16'(nVal), 16'(4 + 2 * k));
      check("dividerR", 16'(rVal), 16'(1 << k));
    end
    flags.extRefStable = 1'b1;
    wrTwo(3'h0, 3'h1);
    wrOne(1'b1, 1'b0, 1'b1, 2'h3);
    check("referenceSelect", 16'(refSel), 16'h0001);
    check("oscAmpEnable", 16'(ampEn), 16'h0001);
    check("highGainSel", 16'(hgSel), 16'h0001);
    check("highGainActive", 16'(hgAct), 16'h0001);
    check("requestedModeSel", 16'(reqMode), 16'h0003);
    tick(12);
    check("actualModeStat", 16'(actMode), 16'h0000);
    measure(100, 50, 0, 17);
    flags.dcoStable = 1'b1;
    waitMode(2'h3);
    check("halfRateActive", 16'(halfRate), 16'h0001);
    measure(50, 25, 25, -1);
    flags.fllLocked = 1'b1;
    tick(4);
    check("halfRateActive", 16'(halfRate), 16'h0000);
    measure(100, 50, 75, -1);
    flags.fllLocked = 1'b0;
    wrTwo(3'h1, 3'h1);
    check("halfRateActive", 16'(halfRate), 16'h0001);
    flags.fllLocked = 1'b1;
    wrTwo(3'h0, 3'h1);
    wrOne(1'b0, 1'b1, 1'b1, 2'h3);
    check("highGainSel", 16'(hgSel), 16'h0001);
    check("prescaleP", 16'(pVal), 16'h0001);
    tick(8);
    measure(100, 50, 50, -1);
    // Loss of the DCO while in the external loop
    flags.lossOfDco = 1'b1;
    tick(1);
    flags.lossOfDco = 1'b0;
    tick(1);
    check("requestedModeSel", 16'(reqMode), 16'h0002);
    check("actualModeStat", 16'(actMode), 16'h0002);
    flags.lossOfClock = 1'b1;
    wrOne(1'b0, 1'b1, 1'b1, 2'h3);
    tick(12);
    check("actualModeStat", 16'(actMode), 16'h0002);
    wrOne(1'b0, 1'b1, 1'b1, 2'h0);
    tick(12);
    check("actualModeStat", 16'(actMode), 16'h0002);
    measure(75, 37, 37, -1);
    // Reference stops while bypassed
    extRun = 1'b0;
    flags.lossOfRef = 1'b1;
    tick(1);
    flags.lossOfRef = 1'b0;
    tick(1);
    check("requestedModeSel", 16'(reqMode), 16'h0000);
    check("actualModeStat", 16'(actMode), 16'h0000);
    extRun = 1'b1;
    wrOne(1'b0, 1'b1, 1'b1, 2'h1);
    tick(2);
    check("actualModeStat", 16'(actMode), 16'h0000);
    waitMode(2'h1);
    f = cFix;
    tick(400);
    check("fixedFreqTick", 16'(cFix - f), 16'h0000);
    // Second reset, first write without a crystal
    doReset();
    wrOne(1'b1, 1'b0, 1'b0, 2'h1);
    check("highGainSel", 16'(hgSel), 16'h0001);
    check("highGainActive", 16'(hgAct), 16'h0000);
    wrOne(1'b0, 1'b0, 1'b1, 2'h3);
    check("referenceSelect", 16'(refSel), 16'h0000);
    check("oscAmpEnable", 16'(ampEn), 16'h0000);
    check("highGainSel", 16'(hgSel), 16'h0001);
    // Bypass on request, held off until the reference is stable
    wrOne(1'b0, 1'b0, 1'b1, 2'h2);
    tick(12);
    check("actualModeStat", 16'(actMode), 16'h0000);
    flags.extRefStable = 1'b1;
    waitMode(2'h2);
    measure(150, 75, 75, -1);
    report_and_stop();
  end
endmodule : clock_mode_select_tb
